/* File: wdtr_top.sv */
// Watchdog timer with timeout interrupt and delayed CPU reset.
// Assumes all inputs synchronous to CORE_CLK_I; NRST_I is the power-on reset.
`timescale 1ns/1ps
`default_nettype none

module wdtr_top
   import wdtr_pkg::*;
#(
   parameter int CNT_W = 35,
   parameter int EXP_BASE = EXP_BASE_DOC
) (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   // Register port
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [DATA_W-1:0] RDATA_O,
   // CPU side
   output logic WDOG_IRQ_O,
   output logic [7:0] IRQ_VECTOR_O,
   output logic WAKE_O,
   output logic CPU_RST_O,
   // Event interrupt
   output logic IRQ_O
);

   // Counter must hold the longest timeout mask, refused at elaboration
   if (EXP_BASE < 1 || EXP_BASE + EXP_MAX_SPAN >= CNT_W || CNT_W > 63) begin : g_bad_cnt_w
      $error("wdtr_top: CNT_W too small for EXP_BASE");
   end

   localparam logic [5:0] BASE6 = 6'(EXP_BASE);
   localparam logic [5:0] STEP6 = 6'(EXP_SEL_STEP);

   function automatic logic [5:0] timeout_exp(input wdtr_cfg_t c);
      logic [5:0] adj;
      adj = EXP_ADJ_MID;
      if (c.cd == 2'b00) begin
         adj = c.mult ? EXP_ADJ_MUL1 : EXP_ADJ_MUL0;
      end else if (c.cd == 2'b11) begin
         adj = EXP_ADJ_SLOW;
      end
      return 6'(BASE6 + STEP6 * {4'h0, c.sel} + adj);
   endfunction

   // Register state
   logic [7:0] clk_ctrl_ff;
   logic [7:0] pwr_mode_ff;
   logic [7:0] irq_en_ff;
   logic [7:0] ext_irq_en_ff;
   logic rst_en_ff;
   logic irq_flag_ff;
   logic cause_flag_ff;
   logic [EVT_W-1:0] evt_stat_ff;
   logic [EVT_W-1:0] evt_mask_ff;
   logic [DATA_W-1:0] rdata_ff;
   wdtr_ta_t ta_state_ff;
   logic [1:0] ta_win_ff;
   // Counter state
   logic [CNT_W-1:0] cnt_ff;
   logic rst_pend_ff;
   logic [RST_CNT_W-1:0] rst_cnt_ff;
   logic cpu_rst_ff;
   logic [7:0] vector_ff;

   // Decoding
   wire wr_ctrl = WR_I && (ADDR_I == ADR_WDOG_CTRL);
   wire wr_clk = WR_I && (ADDR_I == ADR_CLK_CTRL);
   wire wr_pwr = WR_I && (ADDR_I == ADR_PWR_MODE);
   wire wr_ie = WR_I && (ADDR_I == ADR_IRQ_EN);
   wire wr_eie = WR_I && (ADDR_I == ADR_EXT_IRQ_EN);
   wire wr_ta = WR_I && (ADDR_I == ADR_TIMED_ACC);
   wire wr_stat = WR_I && (ADDR_I == ADR_EVT_STAT);
   wire wr_mask = WR_I && (ADDR_I == ADR_EVT_MASK);
   wire ta_open = (ta_state_ff == TA_OPEN);
   wire prot_wr = wr_ctrl && ta_open;
   wire restart = prot_wr && WDATA_I[CTRL_RESTART_BIT];

   // Timeout selection
   wdtr_cfg_t cfg;
   // One driver for the whole struct, so no field is driven apart
   assign cfg = '{sel: {clk_ctrl_ff[CLK_SEL_HI_BIT], clk_ctrl_ff[CLK_SEL_LO_BIT]},
      cd: {pwr_mode_ff[PWR_CD_HI_BIT], pwr_mode_ff[PWR_CD_LO_BIT]},
      mult: pwr_mode_ff[PWR_MULT_BIT]};
   wire [5:0] exp_sel = timeout_exp(cfg);
   wire [CNT_W-1:0] tc_mask = ~({CNT_W{1'b1}} << exp_sel);
   wire timeout = (cnt_ff == tc_mask);
   wire rst_fire = rst_pend_ff && (rst_cnt_ff == '0) && rst_en_ff;
   wire rst_done = rst_pend_ff && (rst_cnt_ff == '0);

   // Next values
   wire [CNT_W-1:0] nxt_cnt = (restart || timeout) ? '0 : CNT_W'(cnt_ff + 1'b1);
   wire nxt_irq_flag = timeout ? 1'b1 :
      ((prot_wr || wr_ctrl) && !WDATA_I[CTRL_IRQF_BIT]) ? 1'b0 : irq_flag_ff;
   wire nxt_cause_flag = rst_fire ? 1'b1 :
      (wr_ctrl && !WDATA_I[CTRL_CAUSE_BIT]) ? 1'b0 : cause_flag_ff;
   wire nxt_rst_en = prot_wr ? WDATA_I[CTRL_RST_EN_BIT] : rst_en_ff;
   wire nxt_rst_pend = timeout ? 1'b1 : (restart || rst_done) ? 1'b0 : rst_pend_ff;
   wire [RST_CNT_W-1:0] nxt_rst_cnt = timeout ? RST_DLY_LOAD :
      (rst_pend_ff ? RST_CNT_W'(rst_cnt_ff - 1'b1) : rst_cnt_ff);
   wire [EVT_W-1:0] evt_in = {rst_fire, timeout};
   wire [EVT_W-1:0] nxt_evt_stat =
      evt_in | (evt_stat_ff & ~(wr_stat ? WDATA_I[EVT_W-1:0] : {EVT_W{1'b0}}));

   // Timed access sequencer
   wdtr_ta_t nxt_ta_state;
   logic [1:0] nxt_ta_win;
   always_comb begin
      nxt_ta_state = ta_state_ff;
      nxt_ta_win = ta_win_ff;
      case (ta_state_ff)
         TA_IDLE: begin
            if (wr_ta && WDATA_I == TA_KEY1) begin
               nxt_ta_state = TA_ARMED;
            end
         end
         TA_ARMED: begin
            if (wr_ta && WDATA_I == TA_KEY2) begin
               nxt_ta_state = TA_OPEN;
               nxt_ta_win = TA_WINDOW;
            end else if (WR_I) begin
               nxt_ta_state = TA_IDLE;
            end
         end
         TA_OPEN: begin
            nxt_ta_win = 2'(ta_win_ff - 1'b1);
            if (ta_win_ff == 2'h1) begin
               nxt_ta_state = TA_IDLE;
            end
         end
         default: begin
            nxt_ta_state = TA_IDLE;
         end
      endcase
   end

   // Read selection
   wire [7:0] ctrl_rd = {4'h0, irq_flag_ff, cause_flag_ff, rst_en_ff, 1'b0};
   wire [7:0] ta_rd = {6'h00, ta_state_ff};
   wire [7:0] nxt_rdata = !RD_I ? 8'h00 :
      (ADDR_I == ADR_WDOG_CTRL) ? ctrl_rd :
      (ADDR_I == ADR_CLK_CTRL) ? clk_ctrl_ff :
      (ADDR_I == ADR_PWR_MODE) ? pwr_mode_ff :
      (ADDR_I == ADR_IRQ_EN) ? irq_en_ff :
      (ADDR_I == ADR_EXT_IRQ_EN) ? ext_irq_en_ff :
      (ADDR_I == ADR_TIMED_ACC) ? ta_rd :
      (ADDR_I == ADR_EVT_STAT) ? {6'h00, evt_stat_ff} :
      (ADDR_I == ADR_EVT_MASK) ? {6'h00, evt_mask_ff} : 8'h00;

   // Configuration registers
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         clk_ctrl_ff <= CLK_CTRL_RST;
         pwr_mode_ff <= PWR_MODE_RST;
         irq_en_ff <= IRQ_EN_RST;
         ext_irq_en_ff <= EXT_IRQ_EN_RST;
         evt_mask_ff <= '0;
      end else begin
         if (wr_clk) clk_ctrl_ff <= WDATA_I;
         if (wr_pwr) pwr_mode_ff <= WDATA_I;
         if (wr_ie) irq_en_ff <= WDATA_I;
         if (wr_eie) ext_irq_en_ff <= WDATA_I;
         if (wr_mask) evt_mask_ff <= WDATA_I[EVT_W-1:0];
      end
   end

   // Flags, timed access and read data
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rst_en_ff <= 1'b0;
         irq_flag_ff <= 1'b0;
         cause_flag_ff <= 1'b0;
         evt_stat_ff <= '0;
         ta_state_ff <= TA_IDLE;
         ta_win_ff <= 2'h0;
         rdata_ff <= 8'h00;
      end else begin
         rst_en_ff <= nxt_rst_en;
         irq_flag_ff <= nxt_irq_flag;
         cause_flag_ff <= nxt_cause_flag;
         evt_stat_ff <= nxt_evt_stat;
         ta_state_ff <= nxt_ta_state;
         ta_win_ff <= nxt_ta_win;
         rdata_ff <= nxt_rdata;
      end
   end

   // Counter chain and reset countdown; the CPU reset pulse does not reset this block
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         cnt_ff <= '0;
         rst_pend_ff <= 1'b0;
         rst_cnt_ff <= '0;
         cpu_rst_ff <= 1'b0;
         vector_ff <= 8'h00;
      end else begin
         cnt_ff <= nxt_cnt;
         rst_pend_ff <= nxt_rst_pend;
         rst_cnt_ff <= nxt_rst_cnt;
         cpu_rst_ff <= rst_fire;
         vector_ff <= WDOG_VECTOR;
      end
   end

   // Outputs
   assign RDATA_O = rdata_ff;
   assign WDOG_IRQ_O = irq_flag_ff && ext_irq_en_ff[EXT_EN_WDOG_BIT]
      && irq_en_ff[IRQ_EN_GLOBAL_BIT];
   assign IRQ_VECTOR_O = vector_ff;
   assign WAKE_O = irq_flag_ff && ext_irq_en_ff[EXT_EN_WDOG_BIT];
   assign CPU_RST_O = cpu_rst_ff;
   assign IRQ_O = |(evt_stat_ff & evt_mask_ff);

endmodule

`default_nettype wire

/* File: wdtr_pkg.sv */
// Package for the watchdog timeout and reset block.
// Assumes one system clock that also serves as the oscillator count clock.
package wdtr_pkg;

   // Register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] ADR_WDOG_CTRL = 4'h0;
   localparam logic [3:0] ADR_CLK_CTRL = 4'h1;
   localparam logic [3:0] ADR_PWR_MODE = 4'h2;
   localparam logic [3:0] ADR_IRQ_EN = 4'h3;
   localparam logic [3:0] ADR_EXT_IRQ_EN = 4'h4;
   localparam logic [3:0] ADR_TIMED_ACC = 4'h5;
   localparam logic [3:0] ADR_EVT_STAT = 4'h6;
   localparam logic [3:0] ADR_EVT_MASK = 4'h7;

   // Field positions
   localparam int CTRL_RESTART_BIT = 0;
   localparam int CTRL_RST_EN_BIT = 1;
   localparam int CTRL_CAUSE_BIT = 2;
   localparam int CTRL_IRQF_BIT = 3;
   localparam int CLK_SEL_HI_BIT = 7;
   localparam int CLK_SEL_LO_BIT = 6;
   localparam int PWR_MULT_BIT = 3;
   localparam int PWR_CD_HI_BIT = 7;
   localparam int PWR_CD_LO_BIT = 6;
   localparam int IRQ_EN_GLOBAL_BIT = 7;
   localparam int EXT_EN_WDOG_BIT = 4;
   localparam int EVT_TIMEOUT_BIT = 0;
   localparam int EVT_RESET_BIT = 1;
   localparam int EVT_W = 2;

   // Values after reset
   localparam logic [7:0] CLK_CTRL_RST = 8'h00;
   localparam logic [7:0] PWR_MODE_RST = 8'h80;
   localparam logic [7:0] IRQ_EN_RST = 8'h00;
   localparam logic [7:0] EXT_IRQ_EN_RST = 8'h00;

   // Timed access key and window
   localparam logic [7:0] TA_KEY1 = 8'hAA;
   localparam logic [7:0] TA_KEY2 = 8'h55;
   localparam logic [1:0] TA_WINDOW = 2'h3;

   // Timeout exponents
   localparam int EXP_BASE_DOC = 15;
   localparam int EXP_SEL_STEP = 3;
   localparam logic [5:0] EXP_ADJ_MUL1 = 6'h00;
   localparam logic [5:0] EXP_ADJ_MUL0 = 6'h01;
   localparam logic [5:0] EXP_ADJ_MID = 6'h02;
   localparam logic [5:0] EXP_ADJ_SLOW = 6'h0A;
   localparam int EXP_MAX_SPAN = 19;

   // Reset delay after timeout, in system clocks
   localparam int RST_DLY_CLKS = 512;
   localparam int RST_CNT_W = 10;
   localparam logic [9:0] RST_DLY_LOAD = 10'(RST_DLY_CLKS - 1);

   // Vector of the watchdog service routine
   localparam logic [7:0] WDOG_VECTOR = 8'h63;

   typedef struct packed {
      logic [1:0] sel;
      logic [1:0] cd;
      logic mult;
   } wdtr_cfg_t;

   typedef enum logic [1:0] {
      TA_IDLE = 2'b00,
      TA_ARMED = 2'b01,
      TA_OPEN = 2'b10
   } wdtr_ta_t;

endpackage

/* File: wdtr_top_sva.sv */
// Checker for the watchdog block, watching only the top ports.
// Assumes the package register map and the fixed service vector.
`timescale 1ns/1ps
`default_nettype none
module wdtr_chk
   import wdtr_pkg::*;
#(
   parameter int CNT_W = 35,
   parameter int EXP_BASE = EXP_BASE_DOC
) (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   // Register port
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [DATA_W-1:0] RDATA_O,
   // CPU side
   input wire logic WDOG_IRQ_O,
   input wire logic [7:0] IRQ_VECTOR_O,
   input wire logic WAKE_O,
   input wire logic CPU_RST_O,
   input wire logic IRQ_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!NRST_I);
   chk_irq_gate: assert property (WDOG_IRQ_O |-> WAKE_O)
      else $error("watchdog request without its enable");
   chk_vector_fixed: assert property ($past(NRST_I) |-> IRQ_VECTOR_O == WDOG_VECTOR)
      else $error("service vector wrong");
   chk_rst_pulse: assert property (CPU_RST_O |=> !CPU_RST_O [*8])
      else $error("cpu reset longer than one cycle");
   chk_wake_sticky: assert property ($fell(WAKE_O) |-> $past(WR_I))
      else $error("wake dropped without a write");
   chk_req_sticky: assert property ($fell(WDOG_IRQ_O) |-> $past(WR_I))
      else $error("request dropped without a write");
   chk_evt_sticky: assert property ($fell(IRQ_O) |-> $past(WR_I))
      else $error("event interrupt dropped without a write");
   chk_restart_reads0: assert property ($past(RD_I) && $past(ADDR_I) == ADR_WDOG_CTRL
      |-> !RDATA_O[CTRL_RESTART_BIT])
      else $error("restart bit read back as one");
   // Read data must not linger, software could mistake stale bytes
   chk_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
      else $error("read data outside read cycle");
   chk_unmapped_rd: assert property ($past(RD_I) && $past(ADDR_I) > 4'h7 |-> RDATA_O == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind wdtr_top wdtr_chk #(.CNT_W(CNT_W), .EXP_BASE(EXP_BASE)) u_chk (
   .CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
   .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .WDOG_IRQ_O(WDOG_IRQ_O),
   .IRQ_VECTOR_O(IRQ_VECTOR_O), .WAKE_O(WAKE_O), .CPU_RST_O(CPU_RST_O), .IRQ_O(IRQ_O));
`default_nettype wire

/* File: tb.sv */
// Testbench for the watchdog block: timeout table, reset path, enables.
// Assumes a shortened count base so every timeout stays short.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import wdtr_pkg::*;
   localparam int EXPB = 2;
   typedef struct {logic [7:0] ck; logic [7:0] pm; int ex;} wdtr_row_t;
   wdtr_row_t rows[8] = '{'{8'h00, 8'h08, 15}, '{8'h40, 8'h08, 18}, '{8'h80, 8'h00, 22},
      '{8'hC0, 8'h40, 26}, '{8'h00, 8'h80, 17}, '{8'h40, 8'h88, 20}, '{8'h40, 8'hC0, 28},
      '{8'h00, 8'hC8, 25}};
   logic [7:0] cancel[2] = '{8'h0B, 8'h08};
   logic CORE_CLK_I = 1'b0;
   logic NRST_I = 1'b0;
   logic [3:0] ADDR_I = 4'h0;
   logic [7:0] WDATA_I = 8'h00;
   logic WR_I = 1'b0;
   logic RD_I = 1'b0;
   logic [7:0] RDATA_O;
   logic [7:0] IRQ_VECTOR_O;
   logic WDOG_IRQ_O, WAKE_O, CPU_RST_O, IRQ_O;
   int err_count = 0;
   int tests_run = 0;
   int n;
   always #12.5 CORE_CLK_I = ~CORE_CLK_I;
   wdtr_top #(.EXP_BASE(EXPB)) DUT (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I),
      .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
      .WDOG_IRQ_O(WDOG_IRQ_O), .IRQ_VECTOR_O(IRQ_VECTOR_O), .WAKE_O(WAKE_O),
      .CPU_RST_O(CPU_RST_O), .IRQ_O(IRQ_O));
   task automatic complete_run();
      $display("Checks run %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CORE_CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'b1;
      @(posedge CORE_CLK_I);
      WR_I <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge CORE_CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge CORE_CLK_I);
      RD_I <= 1'b0;
      #1;
      chk(RDATA_O, exp);
   endtask
   // Protected write lands two cycles after the key, inside the window
   task automatic ta(input logic [7:0] d);
      wr(ADR_TIMED_ACC, TA_KEY1);
      wr(ADR_TIMED_ACC, TA_KEY2);
      wr(ADR_WDOG_CTRL, d);
   endtask
   task automatic wait_hi(input bit rst, input int lim);
      while (((rst ? CPU_RST_O : IRQ_O) !== 1'b1) && n < lim) begin
         @(posedge CORE_CLK_I);
         #1;
         n++;
      end
      if (n >= lim) begin
         err_count++;
         $display("CHECK FAILED at %0t: wait ran out", $time);
         complete_run();
      end
   endtask
   initial begin
      repeat (3) @(posedge CORE_CLK_I);
      NRST_I <= 1'b1;
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00);
      rd(4'h2, 8'h80);
      rd(4'h3, 8'h00);
      rd(4'hF, 8'h00);
      chk(IRQ_VECTOR_O, WDOG_VECTOR);
      wr(ADR_EVT_MASK, 8'h01);
      foreach (rows[i]) begin
         wr(ADR_CLK_CTRL, rows[i].ck);
         wr(ADR_PWR_MODE, rows[i].pm);
         ta(8'h01);
         wr(ADR_EVT_STAT, 8'h03);
         #1;
         n = 2;
         wait_hi(0, 40000);
         chk(n, 1 << (rows[i].ex - EXP_BASE_DOC + EXPB));
      end
      wr(ADR_CLK_CTRL, 8'hC0);
      wr(ADR_PWR_MODE, 8'h40);
      ta(8'h03);
      wr(ADR_EVT_STAT, 8'h03);
      #1;
      n = 2;
      wait_hi(0, 9000);
      chk(n, 8192);
      wait_hi(1, 9000);
      chk(n, 8192 + 512);
      rd(ADR_WDOG_CTRL, 8'h0E);
      rd(ADR_EVT_STAT, 8'h03);
      for (int i = 0; i < 4; i++) begin
         wr(ADR_IRQ_EN, {i[1], 7'h00});
         wr(ADR_EXT_IRQ_EN, {3'h0, i[0], 4'h0});
         #1;
         chk(WDOG_IRQ_O, i == 3);
         chk(WAKE_O, i[0]);
      end
      wr(ADR_WDOG_CTRL, 8'h00);
      rd(ADR_WDOG_CTRL, 8'h02);
      foreach (cancel[i]) begin
         wr(ADR_EVT_STAT, 8'h03);
         #1;
         n = 0;
         wait_hi(0, 9000);
         ta(cancel[i]);
         n = 0;
         repeat (600) begin
            @(posedge CORE_CLK_I);
            #1;
            n += (CPU_RST_O !== 1'b0);
         end
         chk(n, 0);
         rd(ADR_WDOG_CTRL, cancel[i] & 8'hFE);
      end
      complete_run();
   end
endmodule
`default_nettype wire
